/* File: design/wds_pkg.sv */
// Purpose: Shared constants and carriers for the sleep-aware watchdog
// Assumes: 32-bit APB register map, one word per register
// Notes:   Period is 2**period_select base ticks, select clamped to PS_MAX
package wds_pkg;

  // Time base
  localparam int unsigned LFOSC_KHZ      = 31;
  localparam int unsigned BASE_TICK_MS   = 1;
  localparam int unsigned LF_EDGES_PER_TICK = LFOSC_KHZ * BASE_TICK_MS;
  localparam int unsigned CNT_W          = 19;
  localparam int unsigned PS_W           = 5;
  localparam logic [4:0]  PS_MAX         = 5'h12;
  localparam logic [4:0]  PS_RESET       = 5'h0B;

  // Mode field encodings
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_SW        = 2'h1;
  localparam logic [1:0]  MODE_AWAKE     = 2'h2;
  localparam logic [1:0]  MODE_ON        = 2'h3;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_COUNT      = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h10;

  // Field positions
  localparam int unsigned CTRL_SWEN_BIT  = 0;
  localparam int unsigned CTRL_PS_LSB    = 1;
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned STAT_PD_BIT    = 3;
  localparam int unsigned STAT_TO_BIT    = 4;
  localparam int unsigned STAT_MODE_LSB  = 8;
  localparam int unsigned IRQ_RESET_BIT  = 0;
  localparam int unsigned IRQ_WAKE_BIT   = 1;
  localparam int unsigned IRQ_W          = 2;

  // Reset values
  localparam logic        SWEN_RESET     = 1'b0;
  localparam logic        FLAG_RESET     = 1'b1;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_enter;
    logic sleep_exit;
    logic sleeping;
    logic osc_fail;
    logic osc_startup_timer;
  } wds_core_ev_t;

  typedef struct packed {
    logic wdt_reset;
    logic wdt_wake;
    logic timeout_flag;
    logic powerdown_flag;
  } wds_core_out_t;

endpackage : wds_pkg

/* File: design/wds_lf_tick.sv */
// Purpose: Base tick from the low-frequency oscillator pin
// Assumes: Oscillator far slower than clock_i
// Notes:   Counts synchronised rising edges
`timescale 1ns/1ns
`default_nettype none
module wds_lf_tick #(
  parameter int unsigned EDGES = wds_pkg::LF_EDGES_PER_TICK
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic low_freq_internal_osc_i,
  output logic      tick_o
);

  localparam int unsigned DW = $clog2(EDGES + 1);
  localparam logic [DW-1:0] LAST = DW'(EDGES - 1);

  logic          sync1;
  logic          sync2;
  logic          prev;
  logic [DW-1:0] edges;
  logic [DW-1:0] next_edges;
  logic          next_tick;
  logic          rise;

  // Edge taken only from the second stage
  assign rise = sync2 & ~prev;

  always_comb
  begin
    next_edges = edges;
    next_tick  = 1'b0;
    if (rise)
    begin
      if (edges == LAST)
      begin
        next_edges = '0;
        next_tick  = 1'b1;
      end
      else
      begin
        next_edges = edges + DW'(1);
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sync1  <= 1'b0;
      sync2  <= 1'b0;
      prev   <= 1'b0;
      edges  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      sync1  <= low_freq_internal_osc_i;
      sync2  <= sync1;
      prev   <= sync2;
      edges  <= next_edges;
      tick_o <= next_tick;
    end
  end

endmodule : wds_lf_tick
`default_nettype wire

/* File: design/wds_watchdog.sv */
// Purpose: Sleep-aware watchdog timer with APB registers
// Assumes: Clear and sleep entry/exit events are one-cycle pulses on clock_i; sleeping, osc_fail and osc_startup_timer are levels
// Notes:   Oscillator pin is asynchronous and synchronised in wds_lf_tick
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module wds_watchdog #(
  parameter int unsigned LF_EDGES = wds_pkg::LF_EDGES_PER_TICK
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 low_freq_internal_osc_i,
  input  wire logic [1:0]           wdt_mode_cfg_i,
  input  wire wds_pkg::wds_core_ev_t core_ev_i,
  output wds_pkg::wds_core_out_t    core_out_o,
  output logic                      irq_o,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr
);

  logic                    tick;
  logic                    active;
  logic                    hold_clear;
  logic                    expire;
  logic [wds_pkg::CNT_W-1:0] limit;
  logic [wds_pkg::PS_W-1:0]  ps_eff;

  // Counter and flags
  logic [wds_pkg::CNT_W-1:0] count;
  logic [wds_pkg::CNT_W-1:0] next_count;
  logic                    timeout_flag;
  logic                    next_timeout_flag;
  logic                    powerdown_flag;
  logic                    next_powerdown_flag;
  logic                    wdt_reset;
  logic                    next_wdt_reset;
  logic                    wdt_wake;
  logic                    next_wdt_wake;

  // Registers
  logic                    sw_watchdog_enable;
  logic                    next_sw_watchdog_enable;
  logic [wds_pkg::PS_W-1:0]  watchdog_period_select;
  logic [wds_pkg::PS_W-1:0]  next_watchdog_period_select;
  logic [wds_pkg::IRQ_W-1:0] irq_stat;
  logic [wds_pkg::IRQ_W-1:0] next_irq_stat;
  logic [wds_pkg::IRQ_W-1:0] irq_mask;
  logic [wds_pkg::IRQ_W-1:0] next_irq_mask;
  logic [31:0]             rdata;
  logic [31:0]             next_rdata;
  logic                    err;
  logic                    next_err;

  logic                    wr_acc;
  logic                    setup;
  logic                    mapped;

  wds_lf_tick #(
    .EDGES                   (LF_EDGES)
  ) u_tick (
    .clock_i                 (clock_i),
    .rst_n_i                 (rst_n_i),
    .low_freq_internal_osc_i (low_freq_internal_osc_i),
    .tick_o                  (tick)
  );

  always_comb
  begin
    case (wdt_mode_cfg_i)
      wds_pkg::MODE_ON:    active = 1'b1;
      wds_pkg::MODE_AWAKE: active = ~core_ev_i.sleeping;
      wds_pkg::MODE_SW:    active = sw_watchdog_enable;
      default:             active = 1'b0;
    endcase
  end

  // Out-of-range selects clamp to the longest period
  assign ps_eff = (watchdog_period_select > wds_pkg::PS_MAX) ? wds_pkg::PS_MAX
                                                             : watchdog_period_select;
  assign limit  = (wds_pkg::CNT_W'(1) << ps_eff) - wds_pkg::CNT_W'(1);

  assign hold_clear = ~active
                    | core_ev_i.osc_fail
                    | core_ev_i.osc_startup_timer
                    | core_ev_i.clear_watchdog_instr
                    | core_ev_i.sleep_enter
                    | core_ev_i.sleep_exit;

  // At or past the limit, so a period shortened below the count still expires
  assign expire = ~hold_clear & tick & (count >= limit);

  always_comb
  begin
    next_count          = count;
    next_timeout_flag   = timeout_flag;
    next_powerdown_flag = powerdown_flag;
    next_wdt_reset      = 1'b0;
    next_wdt_wake       = 1'b0;
    // No oscillator divider term: the count never sees it
    if (hold_clear)
    begin
      next_count = '0;
    end
    else if (expire)
    begin
      next_count = '0;
    end
    else if (tick)
    begin
      next_count = count + wds_pkg::CNT_W'(1);
    end
    if (core_ev_i.clear_watchdog_instr)
    begin
      next_timeout_flag   = 1'b1;
      next_powerdown_flag = 1'b1;
    end
    else if (core_ev_i.sleep_enter)
    begin
      next_timeout_flag   = 1'b1;
      next_powerdown_flag = 1'b0;
    end
    if (expire)
    begin
      next_timeout_flag = 1'b0;
      if (core_ev_i.sleeping)
      begin
        next_wdt_wake = 1'b1;
      end
      else
      begin
        next_wdt_reset = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      count          <= '0;
      timeout_flag   <= wds_pkg::FLAG_RESET;
      powerdown_flag <= wds_pkg::FLAG_RESET;
      wdt_reset      <= 1'b0;
      wdt_wake       <= 1'b0;
    end
    else
    begin
      count          <= next_count;
      timeout_flag   <= next_timeout_flag;
      powerdown_flag <= next_powerdown_flag;
      wdt_reset      <= next_wdt_reset;
      wdt_wake       <= next_wdt_wake;
    end
  end

  // One process drives the whole carrier
  always_comb
  begin
    core_out_o.wdt_reset      = wdt_reset;
    core_out_o.wdt_wake       = wdt_wake;
    core_out_o.timeout_flag   = timeout_flag;
    core_out_o.powerdown_flag = powerdown_flag;
  end

  // APB slave, zero wait states; read data captured in setup
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    case (paddr)
      wds_pkg::OFS_CTRL,
      wds_pkg::OFS_STATUS,
      wds_pkg::OFS_COUNT,
      wds_pkg::OFS_IRQ_STAT,
      wds_pkg::OFS_IRQ_MASK: mapped = 1'b1;
      default:               mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    next_sw_watchdog_enable     = sw_watchdog_enable;
    next_watchdog_period_select = watchdog_period_select;
    next_irq_mask               = irq_mask;
    next_irq_stat               = irq_stat;
    next_rdata                  = rdata;
    next_err                    = err;
    if (wr_acc && paddr == wds_pkg::OFS_CTRL)
    begin
      next_sw_watchdog_enable     = pwdata[wds_pkg::CTRL_SWEN_BIT];
      next_watchdog_period_select = pwdata[wds_pkg::CTRL_PS_LSB +: wds_pkg::PS_W];
    end
    if (wr_acc && paddr == wds_pkg::OFS_IRQ_MASK)
    begin
      next_irq_mask = pwdata[wds_pkg::IRQ_W-1:0];
    end
    if (wr_acc && paddr == wds_pkg::OFS_IRQ_STAT)
    begin
      next_irq_stat = irq_stat & ~pwdata[wds_pkg::IRQ_W-1:0];
    end
    // Set after clear so a same-cycle event survives
    if (wdt_reset)
    begin
      next_irq_stat[wds_pkg::IRQ_RESET_BIT] = 1'b1;
    end
    if (wdt_wake)
    begin
      next_irq_stat[wds_pkg::IRQ_WAKE_BIT] = 1'b1;
    end
    if (setup)
    begin
      next_err   = ~mapped;
      next_rdata = 32'h0000_0000;
      case (paddr)
        wds_pkg::OFS_CTRL:
        begin
          next_rdata[wds_pkg::CTRL_SWEN_BIT]               = sw_watchdog_enable;
          next_rdata[wds_pkg::CTRL_PS_LSB +: wds_pkg::PS_W] = watchdog_period_select;
        end
        wds_pkg::OFS_STATUS:
        begin
          next_rdata[wds_pkg::STAT_ACTIVE_BIT]    = active;
          next_rdata[wds_pkg::STAT_SLEEP_BIT]     = core_ev_i.sleeping;
          next_rdata[wds_pkg::STAT_PD_BIT]        = powerdown_flag;
          next_rdata[wds_pkg::STAT_TO_BIT]        = timeout_flag;
          next_rdata[wds_pkg::STAT_MODE_LSB +: 2] = wdt_mode_cfg_i;
        end
        wds_pkg::OFS_COUNT:    next_rdata[wds_pkg::CNT_W-1:0] = count;
        wds_pkg::OFS_IRQ_STAT: next_rdata[wds_pkg::IRQ_W-1:0] = irq_stat;
        wds_pkg::OFS_IRQ_MASK: next_rdata[wds_pkg::IRQ_W-1:0] = irq_mask;
        default:               next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sw_watchdog_enable     <= wds_pkg::SWEN_RESET;
      watchdog_period_select <= wds_pkg::PS_RESET;
      irq_mask               <= wds_pkg::IRQ_MASK_RESET;
      irq_stat               <= '0;
      rdata                  <= 32'h0000_0000;
      err                    <= 1'b0;
    end
    else
    begin
      sw_watchdog_enable     <= next_sw_watchdog_enable;
      watchdog_period_select <= next_watchdog_period_select;
      irq_mask               <= next_irq_mask;
      irq_stat               <= next_irq_stat;
      rdata                  <= next_rdata;
      err                    <= next_err;
    end
  end

  assign prdata  = rdata;
  assign pslverr = err & psel & penable;
  assign irq_o   = |(irq_stat & irq_mask);

endmodule : wds_watchdog
`default_nettype wire

/* File: sim/wds_watchdog_assertions.sv */
// Purpose: Port checks for the sleep-aware watchdog
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every wds_watchdog
`timescale 1ns/1ns
`default_nettype none
module wds_watchdog_chk #(
  parameter int unsigned LF_EDGES = wds_pkg::LF_EDGES_PER_TICK
) (
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  input wire logic [1:0]             wdt_mode_cfg_i,
  input wire wds_pkg::wds_core_ev_t  core_ev_i,
  input wire wds_pkg::wds_core_out_t core_out_o
);
  wire logic rs  = core_out_o.wdt_reset;
  wire logic wk  = core_out_o.wdt_wake;
  wire logic tof = core_out_o.timeout_flag;
  wire logic pdf = core_out_o.powerdown_flag;
  wire logic slp = core_ev_i.sleeping;
  wire logic clr = core_ev_i.clear_watchdog_instr;
  wire logic ent = core_ev_i.sleep_enter;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_clear_sets_flags: assert property (clr && !ent |=> tof && pdf)
    else $error("flags not set after clear");
  a_sleep_drops_pd: assert property (ent && !clr |=> !pdf && tof)
    else $error("flags wrong after sleep entry");
  a_pulse_single: assert property (rs |=> !rs)
    else $error("reset pulse longer than one cycle");
  a_reset_when_awake: assert property (rs |-> !$past(slp) && !tof && !wk)
    else $error("reset pulse while asleep");
  a_wake_when_asleep: assert property (wk |-> $past(slp) && !tof)
    else $error("wake pulse while awake");
  a_off_quiet: assert property ((wdt_mode_cfg_i == wds_pkg::MODE_OFF)[*2] |-> !rs && !wk)
    else $error("time-out in off mode");
  a_awake_mode_sleep: assert property ((wdt_mode_cfg_i == wds_pkg::MODE_AWAKE && slp)[*2] |-> !wk)
    else $error("wake in awake-only mode");
  a_hold_quiet: assert property ((core_ev_i.osc_startup_timer || core_ev_i.osc_fail)[*2] |-> !rs && !wk)
    else $error("time-out while held clear");
  a_timeout_clears: assert property ($fell(tof) |-> rs || wk)
    else $error("timeout flag fell without time-out");
  a_pd_by_sleep: assert property ($fell(pdf) |-> $past(ent))
    else $error("powerdown flag fell without sleep");
endmodule : wds_watchdog_chk
bind wds_watchdog wds_watchdog_chk #(.LF_EDGES(LF_EDGES)) wds_watchdog_chk_inst (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .wdt_mode_cfg_i(wdt_mode_cfg_i),
  .core_ev_i(core_ev_i),
  .core_out_o(core_out_o)
);
`default_nettype wire

/* File: sim/wds_core_model.sv */
// Purpose: Core and power-mode model facing the watchdog
// Assumes: Commands issued between clock edges
// Notes:   Wakes by itself on a wake pulse, like a real core
`timescale 1ns/1ns
`default_nettype none
module wds_core_model (
  input  wire logic             clock_i,
  input  wire logic             wake_i,
  output wds_pkg::wds_core_ev_t ev_o,
  output logic                  osc_o
);
  logic [2:0] req = 3'h0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] div = 2'h0;
  initial
  begin
    ev_o = '0;
    osc_o = 1'b0;
  end
  // Oscillator runs free, period of eight clocks
  always @(posedge clock_i)
  begin
    div <= div + 2'h1;
    if (div == 2'h3)
      osc_o <= ~osc_o;
    ev_o.clear_watchdog_instr <= req[0];
    ev_o.sleep_enter <= req[1];
    ev_o.sleep_exit <= ev_o.sleeping && (req[2] || wake_i);
    ev_o.sleeping <= (ev_o.sleeping || req[1]) && !(req[2] || wake_i);
    ev_o.osc_startup_timer <= lvl[1];
    ev_o.osc_fail <= lvl[0];
    req <= 3'h0;
  end
  // Bit 0 clear, bit 1 sleep, bit 2 wake
  task cmd(input logic [2:0] c);
    #1;
    req = c;
  endtask : cmd
  task hold(input logic [1:0] l);
    #1;
    lvl = l;
  endtask : hold
endmodule : wds_core_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the sleep-aware watchdog
// Assumes: Base tick shortened to two oscillator edges
// Notes:   Tick every 16 clocks, period 2**ps ticks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                   clock_i;
  logic                   rst_n_i;
  logic [1:0]             mode;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  logic                   irq;
  logic                   osc;
  wds_pkg::wds_core_ev_t  ev;
  wds_pkg::wds_core_out_t co;
  logic [31:0]            rdv;
  logic                   err;
  int                     failures = 0;
  int                     num_checks = 0;
  wds_core_model wds_core_model_inst (
    .clock_i(clock_i),
    .wake_i(co.wdt_wake),
    .ev_o(ev),
    .osc_o(osc)
  );
  wds_watchdog #(.LF_EDGES(2)) wds_watchdog_inst (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .low_freq_internal_osc_i(osc),
    .wdt_mode_cfg_i(mode),
    .core_ev_i(ev),
    .core_out_o(co),
    .irq_o(irq),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr)
  );
  always #20 clock_i = ~clock_i;
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask : rd
  // Stops at the first pulse; none expected means watch the whole span
  task wait_to(input logic [1:0] exp, input int n);
    logic [1:0] seen;
    seen = 2'h0;
    for (int i = 0; i < n && seen == 2'h0; i++)
    begin
      @(posedge clock_i);
      #1;
      seen = {co.wdt_reset, co.wdt_wake};
    end
    chk("time-out", {30'h0, exp}, {30'h0, seen});
  endtask : wait_to
  task flags(input logic [1:0] exp);
    chk("flags", {30'h0, exp}, {30'h0, co.timeout_flag, co.powerdown_flag});
  endtask : flags
  task set_mode(input logic [1:0] m);
    @(posedge clock_i);
    mode <= m;
  endtask : set_mode
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    #400000;
    failures++;
    conclude();
  end
  initial
  begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    mode    = wds_pkg::MODE_ON;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(wds_pkg::OFS_CTRL, 32'h16, "ctrl");
    rd(wds_pkg::OFS_STATUS, 32'h319, "status");
    rd(wds_pkg::OFS_IRQ_MASK, 32'h0, "irq mask");
    rd(8'h14, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, wds_pkg::OFS_CTRL, 32'h0);
    wait_to(2'b10, 200);
    flags(2'b01);
    set_mode(wds_pkg::MODE_OFF);
    wait_to(2'b00, 300);
    rd(wds_pkg::OFS_COUNT, 32'h0, "count");
    rd(wds_pkg::OFS_IRQ_STAT, 32'h1, "irq stat");
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, wds_pkg::OFS_IRQ_MASK, 32'h3);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, wds_pkg::OFS_IRQ_STAT, 32'h1);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    // Clear every 40 clocks, four ticks need at least 49
    apb(1'b1, wds_pkg::OFS_CTRL, 32'h4);
    set_mode(wds_pkg::MODE_ON);
    repeat (8)
    begin
      wds_core_model_inst.cmd(3'h1);
      wait_to(2'b00, 40);
    end
    flags(2'b11);
    wds_core_model_inst.cmd(3'h2);
    wait_to(2'b00, 40);
    flags(2'b10);
    wait_to(2'b01, 100);
    flags(2'b00);
    rd(wds_pkg::OFS_IRQ_STAT, 32'h2, "irq stat");
    set_mode(wds_pkg::MODE_AWAKE);
    wds_core_model_inst.cmd(3'h2);
    wait_to(2'b00, 300);
    wds_core_model_inst.cmd(3'h4);
    wait_to(2'b10, 200);
    set_mode(wds_pkg::MODE_SW);
    wait_to(2'b00, 300);
    apb(1'b1, wds_pkg::OFS_CTRL, 32'h5);
    wait_to(2'b10, 200);
    rd(wds_pkg::OFS_CTRL, 32'h5, "ctrl");
    wds_core_model_inst.hold(2'b10);
    set_mode(wds_pkg::MODE_ON);
    wait_to(2'b00, 300);
    wds_core_model_inst.hold(2'b01);
    wait_to(2'b00, 300);
    wds_core_model_inst.hold(2'b00);
    wait_to(2'b10, 200);
    // Second reset in mid-run restores flags and period
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    flags(2'b11);
    rd(wds_pkg::OFS_CTRL, 32'h16, "ctrl");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
